// >>> src/nap_array_guard.v
// protection check, page cache and correction sequencer
// What this block does
// - tb=0: codes 0011..1001 protect top 16 blocks up to top half
// - tb=1: codes 0001..1001 protect lowest 4 up to 1024 blocks
// - codes 101x and 11xx protect all 2048 blocks
// - code 0000 protects nothing, whatever tb says
// - tb=0: 0001 covers 2044..2047, 0010 covers 2040..2047
// - program or erase touching a protected block is dropped
// - correction enable is config bit 4, set after power-up
// - device reset command keeps correction enable as it is
// - program computes sector parity into spare area first
// - read recomputes parity, fixes cache, outputs fixed data
// - status bits report result of the latest read
// - status 00 up to one fixed bit per sector, 10 failed; 01 is never set
// - power-on loads page 0 of block 0 with correction
// - main area is four 512-byte sectors 000h..7ffh
// - bytes 800h..83fh are protected metadata
// - sector parity 16 bytes each from 840h to 87fh
// - byte 2048 of page 0 is the bad-block marker spot
// - at least 2008 of 2048 blocks stay valid
// - at most one bit corrected per 512-byte sector
`timescale 1ns/10ps
`include "nap_defines.vh"
module nap_array_guard (
   // clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   // protect setting
   input  wire        i_top_bottom_select,
   input  wire        i_block_protect_level_3,
   input  wire        i_block_protect_level_2,
   input  wire        i_block_protect_level_1,
   input  wire        i_block_protect_level_0,
   // configuration and device reset
   input  wire        i_cfg_wr,
   input  wire [7:0]  i_cfg_data,
   input  wire        i_dev_reset,
   // operation request
   input  wire        i_op_req,
   input  wire [1:0]  i_op_kind,
   input  wire [16:0] i_row_addr,
   // host cache port
   input  wire        i_cache_wr,
   input  wire [11:0] i_cache_addr,
   input  wire [7:0]  i_cache_wdata,
   output reg  [7:0]  o_cache_rdata_r,
   // array side
   output reg         o_arr_rd_en_r,
   output reg         o_arr_wr_en_r,
   output reg         o_arr_erase_r,
   output reg  [16:0] o_arr_row_r,
   output reg  [11:0] o_arr_addr_r,
   output reg  [7:0]  o_arr_wdata_r,
   input  wire [7:0]  i_arr_rdata,
   // status
   output reg         o_busy_r,
   output reg         o_op_reject_r,
   output reg         o_ecc_enable_r,
   output reg  [1:0]  o_ecc_status_r
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_LOAD  = 3'h2;
   localparam [2:0] ST_DRAIN = 3'h3;
   localparam [2:0] ST_CALC  = 3'h4;
   localparam [2:0] ST_FIX   = 3'h5;
   localparam [2:0] ST_PROG  = 3'h6;
   localparam [2:0] ST_DONE  = 3'h7;

   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   reg [7:0]  cache [0:2175];
   reg [2:0]  state_r;
   reg [1:0]  op_r;
   reg [16:0] row_r;
   reg [11:0] ptr_r;
   reg [1:0]  sec_r;
   reg [9:0]  idx_r;
   reg        pend_r;
   reg [11:0] pend_addr_r;
   reg [3:0]  fix_max_r;
   reg        fail_r;

   wire        prot_none;
   wire [10:0] prot_lo;
   wire [10:0] prot_hi;
   wire [7:0]  par_col;
   wire [12:0] par_loc;
   wire [10:0] req_blk;
   wire        req_hit;
   wire [11:0] sec_base;
   wire [11:0] byte_addr;
   wire [11:0] par_addr;
   wire [9:0]  sec_last;
   wire [7:0]  syn_col;
   wire [12:0] syn_loc;
   wire [11:0] fix_addr;
   wire        calc_en;

   // ------------------------------------------------------------
   // protection range
   // ------------------------------------------------------------
   nap_protect_decode u_decode (
      .i_top_bottom_select (i_top_bottom_select),
      .i_bp                ({i_block_protect_level_3,
                             i_block_protect_level_2,
                             i_block_protect_level_1,
                             i_block_protect_level_0}),
      .o_none              (prot_none),
      .o_lo                (prot_lo),
      .o_hi                (prot_hi)
   );

   assign req_blk = row_r[`NAP_BLOCK_MSB:`NAP_BLOCK_LSB];
   assign req_hit = !prot_none && (req_blk >= prot_lo) &&
                    (req_blk <= prot_hi);

   // ------------------------------------------------------------
   // sector walk
   // ------------------------------------------------------------
   function [7:0] ones;
      input [7:0] v;
      integer k;
      begin
         ones = 8'h00;
         for (k = 0; k < 8; k = k + 1)
            ones = ones + {7'h00, v[k]};
      end
   endfunction

   // sector 3 runs on through the metadata bytes
   assign sec_base  = {1'b0, sec_r, 9'h000};
   assign sec_last  = (sec_r == 2'h3) ? `NAP_META_LAST
                                      : `NAP_SECTOR_LAST;
   assign byte_addr = sec_base + {2'b00, idx_r};
   assign par_addr  = `NAP_PARITY_BASE +
                      {6'h00, sec_r, 4'h0};
   assign syn_col   = par_col ^ cache[par_addr];
   assign syn_loc   = par_loc ^ {cache[par_addr + 12'h002][4:0],
                                 cache[par_addr + 12'h001]};
   assign fix_addr  = sec_base + {2'b00, syn_loc[12:3]};
   assign calc_en   = (state_r == ST_CALC);

   nap_sector_parity u_parity (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_clr     (state_r == ST_FIX),
      .i_en      (calc_en),
      .i_idx     (idx_r),
      .i_byte    (cache[byte_addr]),
      .o_col_r   (par_col),
      .o_loc_r   (par_loc)
   );

   // ------------------------------------------------------------
   // cache writes
   // ------------------------------------------------------------
   always @(posedge i_ref_clk) begin
      if (state_r == ST_IDLE && i_cache_wr &&
          i_cache_addr <= `NAP_PAGE_LAST &&
          !(o_ecc_enable_r &&
            i_cache_addr >= `NAP_PARITY_BASE)) begin
         cache[i_cache_addr] <= i_cache_wdata;
      end else if (pend_r) begin
         cache[pend_addr_r] <= i_arr_rdata;
      end else if (state_r == ST_FIX && op_r == `NAP_OP_PROG) begin
         cache[par_addr]          <= par_col;
         cache[par_addr + 12'h001] <= par_loc[7:0];
         cache[par_addr + 12'h002] <= {3'h0, par_loc[12:8]};
      end else if (state_r == ST_FIX && syn_col != 8'h00 &&
                   ones(syn_col) == 8'h01 &&
                   syn_loc[12:3] <= sec_last) begin
         cache[fix_addr] <= cache[fix_addr] ^
                            (8'h01 << syn_loc[2:0]);
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_r         <= ST_LOAD;
         op_r            <= `NAP_OP_READ;
         row_r           <= 17'h00000;
         ptr_r           <= 12'h000;
         sec_r           <= 2'h0;
         idx_r           <= 10'h000;
         pend_r          <= 1'b0;
         pend_addr_r     <= 12'h000;
         fix_max_r       <= 4'h0;
         fail_r          <= 1'b0;
         o_cache_rdata_r <= 8'h00;
         o_arr_rd_en_r   <= 1'b0;
         o_arr_wr_en_r   <= 1'b0;
         o_arr_erase_r   <= 1'b0;
         o_arr_row_r     <= 17'h00000;
         o_arr_addr_r    <= 12'h000;
         o_arr_wdata_r   <= 8'h00;
         o_busy_r        <= 1'b1;
         o_op_reject_r   <= 1'b0;
         o_ecc_enable_r  <= `NAP_ECC_EN_RESET;
         o_ecc_status_r  <= `NAP_ECC_OK;
      end else begin
         pend_r        <= o_arr_rd_en_r;
         pend_addr_r   <= o_arr_addr_r;
         o_arr_rd_en_r <= 1'b0;
         o_arr_wr_en_r <= 1'b0;
         o_arr_erase_r <= 1'b0;
         o_op_reject_r <= 1'b0;
         o_cache_rdata_r <= (i_cache_addr <= `NAP_PAGE_LAST) ?
                            cache[i_cache_addr] : 8'h00;
         if (i_cfg_wr && state_r == ST_IDLE)
            o_ecc_enable_r <= i_cfg_data[`NAP_CFG_ECC_BIT];
         if (i_dev_reset) begin
            state_r        <= ST_IDLE;
            o_busy_r       <= 1'b0;
            o_ecc_status_r <= `NAP_ECC_OK;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (i_op_req) begin
                     op_r     <= i_op_kind;
                     row_r    <= i_row_addr;
                     o_busy_r <= 1'b1;
                     state_r  <= ST_CHECK;
                  end
               end
               ST_CHECK: begin
                  ptr_r       <= 12'h000;
                  sec_r       <= 2'h0;
                  idx_r       <= 10'h000;
                  fix_max_r   <= 4'h0;
                  fail_r      <= 1'b0;
                  o_arr_row_r <= row_r;
                  if (op_r != `NAP_OP_READ && req_hit) begin
                     o_op_reject_r <= 1'b1;
                     state_r       <= ST_DONE;
                  end else if (op_r == `NAP_OP_ERASE) begin
                     o_arr_erase_r <= 1'b1;
                     state_r       <= ST_DONE;
                  end else if (op_r == `NAP_OP_PROG) begin
                     state_r <= o_ecc_enable_r ? ST_CALC
                                               : ST_PROG;
                  end else begin
                     state_r <= ST_LOAD;
                  end
               end
               ST_LOAD: begin
                  o_arr_row_r   <= row_r;
                  o_arr_rd_en_r <= 1'b1;
                  o_arr_addr_r  <= ptr_r;
                  ptr_r         <= ptr_r + 12'h001;
                  if (ptr_r == `NAP_PAGE_LAST)
                     state_r <= ST_DRAIN;
               end
               ST_DRAIN: begin
                  if (!o_arr_rd_en_r && !pend_r) begin
                     fix_max_r <= 4'h0;
                     fail_r    <= 1'b0;
                     sec_r     <= 2'h0;
                     idx_r     <= 10'h000;
                     state_r   <= o_ecc_enable_r ? ST_CALC
                                                 : ST_DONE;
                  end
               end
               ST_CALC: begin
                  idx_r <= idx_r + 10'h001;
                  if (idx_r == sec_last)
                     state_r <= ST_FIX;
               end
               ST_FIX: begin
                  if (op_r == `NAP_OP_READ) begin
                     if (syn_col != 8'h00 || syn_loc != 13'h0000) begin
                        if (ones(syn_col) == 8'h01 &&
                            syn_loc[12:3] <= sec_last) begin
                           if (fix_max_r == 4'h0)
                              fix_max_r <= 4'h1;
                        end else begin
                           fail_r <= 1'b1;
                        end
                     end
                  end
                  idx_r <= 10'h000;
                  sec_r <= sec_r + 2'h1;
                  if (sec_r == 2'h3) begin
                     ptr_r   <= 12'h000;
                     state_r <= (op_r == `NAP_OP_PROG) ? ST_PROG
                                                        : ST_DONE;
                  end else begin
                     state_r <= ST_CALC;
                  end
               end
               ST_PROG: begin
                  o_arr_wr_en_r <= 1'b1;
                  o_arr_addr_r  <= ptr_r;
                  o_arr_wdata_r <= cache[ptr_r];
                  ptr_r         <= ptr_r + 12'h001;
                  if (ptr_r == `NAP_PAGE_LAST)
                     state_r <= ST_DONE;
               end
               default: begin
                  if (op_r == `NAP_OP_READ && o_ecc_enable_r) begin
                     if (fail_r)
                        o_ecc_status_r <= `NAP_ECC_FAIL;
                     else if (fix_max_r >= `NAP_ECC_HEAVY_MIN)
                        o_ecc_status_r <= `NAP_ECC_HEAVY;
                     else
                        o_ecc_status_r <= `NAP_ECC_OK;
                  end
                  o_busy_r <= 1'b0;
                  state_r  <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // nap_array_guard

// >>> src/nap_defines.vh
// constants for the array protection and correction block
`ifndef NAP_DEFINES_VH
`define NAP_DEFINES_VH
// ---------------------------------------------------------------
// page layout
// ---------------------------------------------------------------
`define NAP_PAGE_LAST      12'h87f
`define NAP_SECTOR_BYTES   12'h200
`define NAP_SECTOR_LAST    10'h1ff
`define NAP_META_LAST      10'h23f
`define NAP_PARITY_BASE    12'h840
`define NAP_PARITY_BYTES   12'h010
`define NAP_BAD_MARK_ADDR  12'h800
`define NAP_BAD_MARK_GOOD  8'hff
// ---------------------------------------------------------------
// configuration and status
// ---------------------------------------------------------------
`define NAP_CFG_ECC_BIT    4
`define NAP_ECC_EN_RESET   1'b1
`define NAP_ECC_OK         2'h0
`define NAP_ECC_HEAVY      2'h1
`define NAP_ECC_FAIL       2'h2
`define NAP_ECC_HEAVY_MIN  4'h7
`define NAP_ECC_MAX_FIX    4'h8
// ---------------------------------------------------------------
// array geometry and operations
// ---------------------------------------------------------------
`define NAP_BLOCK_MSB      16
`define NAP_BLOCK_LSB      6
`define NAP_BLOCK_COUNT    12'h800
`define NAP_MIN_VALID_BLK  12'h7d8
`define NAP_OP_READ        2'h0
`define NAP_OP_PROG        2'h1
`define NAP_OP_ERASE       2'h2
`endif

// >>> src/nap_protect_decode.v
// block protect code to protected block range decode
`timescale 1ns/10ps
`include "nap_defines.vh"
module nap_protect_decode (
   // protect setting
   input  wire        i_top_bottom_select,
   input  wire [3:0]  i_bp,
   // decoded range
   output reg         o_none,
   output reg  [10:0] o_lo,
   output reg  [10:0] o_hi
);
   reg [11:0] size;
   reg [11:0] lo_w;
   reg [11:0] hi_w;
   reg        all;
   always @* begin
      size   = 12'h004 << (i_bp - 4'h1);
      lo_w   = `NAP_BLOCK_COUNT - size;
      hi_w   = size - 12'h001;
      all    = (i_bp[3] & i_bp[2]) | (i_bp[3] & ~i_bp[2] & i_bp[1]);
      o_none = (i_bp == 4'h0);
      o_lo   = 11'h000;
      o_hi   = 11'h7ff;
      if (all) begin
         o_lo = 11'h000;
         o_hi = 11'h7ff;
      end else if (!i_top_bottom_select) begin
         o_lo = lo_w[10:0];
         o_hi = 11'h7ff;
      end else begin
         o_lo = 11'h000;
         o_hi = hi_w[10:0];
      end
   end
endmodule // nap_protect_decode

// >>> src/nap_sector_parity.v
// per-sector parity accumulator: column parity and bit locator
`timescale 1ns/10ps
module nap_sector_parity (
   // clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   // byte stream
   input  wire        i_clr,
   input  wire        i_en,
   input  wire [9:0]  i_idx,
   input  wire [7:0]  i_byte,
   // parity
   output reg  [7:0]  o_col_r,
   output reg  [12:0] o_loc_r
);
   function [12:0] fold;
      input [9:0] idx;
      input [7:0] b;
      integer k;
      begin
         fold = 13'h0000;
         for (k = 0; k < 8; k = k + 1)
            if (b[k])
               fold = fold ^ {idx, k[2:0]};
      end
   endfunction

   always @(posedge i_ref_clk) begin
      if (!i_rst_n || i_clr) begin
         o_col_r <= 8'h00;
         o_loc_r <= 13'h0000;
      end else if (i_en) begin
         o_col_r <= o_col_r ^ i_byte;
         o_loc_r <= o_loc_r ^ fold(i_idx, i_byte);
      end
   end
endmodule // nap_sector_parity

// >>> test/nap_array_model.sv
// behavioural nand array answering the guard's array strobes
`timescale 1ns/10ps
module nap_array_model (
   // clock
   input  wire        i_ref_clk,
   // array strobes
   input  wire        i_rd_en,
   input  wire        i_wr_en,
   input  wire        i_erase,
   input  wire [16:0] i_row,
   input  wire [11:0] i_addr,
   input  wire [7:0]  i_wdata,
   // read data
   output logic [7:0] o_rdata
);
   logic [7:0]  mem [logic [28:0]];
   logic [28:0] dq [$];
   initial o_rdata = 8'h00;
   // data one cycle after strobe, else a changing pattern
   always @(posedge i_ref_clk) begin
      if (i_rd_en)
         o_rdata <= mem.exists({i_row, i_addr}) ?
                    mem[{i_row, i_addr}] : 8'hff;
      else
         o_rdata <= ~o_rdata;
      if (i_wr_en)
         mem[{i_row, i_addr}] = i_wdata;
      if (i_erase) begin
         dq.delete();
         foreach (mem[a]) if (a[28:18] == i_row[16:6]) dq.push_back(a);
         foreach (dq[j]) mem.delete(dq[j]);
      end
   end
endmodule // nap_array_model

// >>> test/nap_array_guard_assertions.sv
// concurrent checks on the guard's ports
`timescale 1ns/10ps
`include "nap_defines.vh"
module nap_array_guard_chk (
   // clock and reset
   input wire        i_ref_clk,
   input wire        i_rst_n,
   // control inputs
   input wire        i_block_protect_level_3,
   input wire        i_block_protect_level_2,
   input wire        i_block_protect_level_1,
   input wire        i_block_protect_level_0,
   input wire        i_cfg_wr,
   input wire [7:0]  i_cfg_data,
   input wire        i_dev_reset,
   input wire        i_op_req,
   input wire [1:0]  i_op_kind,
   // outputs
   input wire        o_arr_rd_en_r,
   input wire        o_arr_wr_en_r,
   input wire        o_arr_erase_r,
   input wire [11:0] o_arr_addr_r,
   input wire        o_busy_r,
   input wire        o_op_reject_r,
   input wire        o_ecc_enable_r,
   input wire [1:0]  o_ecc_status_r
);
   wire       take;
   wire [3:0] bp;
   assign take = i_op_req && !o_busy_r && !i_dev_reset;
   assign bp = {i_block_protect_level_3, i_block_protect_level_2,
                i_block_protect_level_1, i_block_protect_level_0};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   a_take_busy: assert property (take |=> o_busy_r)
      else $error("request not answered by busy");
   a_all_prot: assert property (
      take && i_op_kind != `NAP_OP_READ && bp[3] && (bp[2] || bp[1])
      |-> ##[2:3] o_op_reject_r) else $error("full protect not rejected");
   a_none_free: assert property (
      take && bp == 4'h0 |-> ##1 !o_op_reject_r [*3])
      else $error("reject with protect code zero");
   a_read_free: assert property (
      take && i_op_kind == `NAP_OP_READ |-> ##1 !o_op_reject_r [*3])
      else $error("read was rejected");
   a_rej_quiet: assert property (
      o_op_reject_r |-> !o_arr_erase_r && !o_arr_wr_en_r ##[1:2] !o_busy_r)
      else $error("rejected operation touched array");
   a_dev_keep: assert property (
      i_dev_reset && !i_cfg_wr |=> o_ecc_enable_r == $past(o_ecc_enable_r)
      && o_ecc_status_r == `NAP_ECC_OK && !o_busy_r)
      else $error("device reset result wrong");
   a_cfg_bit: assert property (
      i_cfg_wr && !o_busy_r && !i_dev_reset
      |=> o_ecc_enable_r == $past(i_cfg_data[`NAP_CFG_ECC_BIT]))
      else $error("enable not taken from bit 4");
   a_wr_page: assert property (
      o_arr_wr_en_r |-> o_arr_addr_r <= `NAP_PAGE_LAST && o_busy_r)
      else $error("array write outside page");
   a_idle_quiet: assert property (
      !o_busy_r |-> !o_arr_rd_en_r && !o_arr_wr_en_r && !o_arr_erase_r)
      else $error("array strobe while idle");
   a_stat_hold: assert property (
      $changed(o_ecc_status_r) |-> $past(o_busy_r) || $past(i_dev_reset))
      else $error("status changed outside an operation");
   c_reject: cover property (o_op_reject_r);
   c_erase: cover property (o_arr_erase_r);
   c_fail: cover property (o_ecc_status_r == `NAP_ECC_FAIL);
   c_read: cover property (take && i_op_kind == `NAP_OP_READ);
endmodule // nap_array_guard_chk
bind nap_array_guard nap_array_guard_chk u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_block_protect_level_3(i_block_protect_level_3),
   .i_block_protect_level_2(i_block_protect_level_2),
   .i_block_protect_level_1(i_block_protect_level_1),
   .i_block_protect_level_0(i_block_protect_level_0),
   .i_cfg_wr(i_cfg_wr), .i_cfg_data(i_cfg_data), .i_dev_reset(i_dev_reset),
   .i_op_req(i_op_req), .i_op_kind(i_op_kind),
   .o_arr_rd_en_r(o_arr_rd_en_r), .o_arr_wr_en_r(o_arr_wr_en_r),
   .o_arr_erase_r(o_arr_erase_r), .o_arr_addr_r(o_arr_addr_r),
   .o_busy_r(o_busy_r), .o_op_reject_r(o_op_reject_r),
   .o_ecc_enable_r(o_ecc_enable_r), .o_ecc_status_r(o_ecc_status_r));

// >>> test/nap_array_guard_tb_top.sv
// self-checking bench for the array protection and correction block
`timescale 1ns/10ps
`include "nap_defines.vh"
module nap_array_guard_tb_top;
   logic        i_ref_clk, i_rst_n, tbs, i_cfg_wr, i_dev_reset, i_op_req;
   logic [3:0]  bp;
   logic [7:0]  i_cfg_data, i_cache_wdata, rdata, wdata, i_arr_rdata;
   logic [1:0]  i_op_kind, stat;
   logic [16:0] i_row_addr, arow;
   logic [11:0] i_cache_addr, aaddr;
   logic        i_cache_wr, rd_en, wr_en, ers, busy, rej, ecc_en;
   logic        s_rej, s_ers, s_wr;
   logic [10:0] erow;
   int          failures, num_checks, nrd, i, t, c, k;
   logic [10:0] blk [6];
   localparam logic [16:0] PA = {11'd100, 6'd3}, PB = {11'd101, 6'd0};
   nap_array_guard uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_top_bottom_select(tbs), .i_block_protect_level_3(bp[3]),
      .i_block_protect_level_2(bp[2]), .i_block_protect_level_1(bp[1]),
      .i_block_protect_level_0(bp[0]), .i_cfg_wr(i_cfg_wr),
      .i_cfg_data(i_cfg_data), .i_dev_reset(i_dev_reset),
      .i_op_req(i_op_req), .i_op_kind(i_op_kind), .i_row_addr(i_row_addr),
      .i_cache_wr(i_cache_wr), .i_cache_addr(i_cache_addr),
      .i_cache_wdata(i_cache_wdata), .o_cache_rdata_r(rdata),
      .o_arr_rd_en_r(rd_en), .o_arr_wr_en_r(wr_en), .o_arr_erase_r(ers),
      .o_arr_row_r(arow), .o_arr_addr_r(aaddr), .o_arr_wdata_r(wdata),
      .i_arr_rdata(i_arr_rdata), .o_busy_r(busy), .o_op_reject_r(rej),
      .o_ecc_enable_r(ecc_en), .o_ecc_status_r(stat));
   nap_array_model u_arr (.i_ref_clk(i_ref_clk), .i_rd_en(rd_en),
      .i_wr_en(wr_en), .i_erase(ers), .i_row(arow), .i_addr(aaddr),
      .i_wdata(wdata), .o_rdata(i_arr_rdata));
   initial begin
      i_ref_clk = 0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // pulse capture off the sampling edge
   always @(negedge i_ref_clk) begin
      s_rej |= rej; s_wr |= wr_en; s_ers |= ers;
      if (ers) erow = arow[16:6];
      if (rd_en && arow == 17'h0) nrd++;
   end
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction
   function automatic bit prot(input bit tb, input logic [3:0] c,
                               input logic [10:0] b);
      int n;
      n = 4 << (c - 1);
      if (c == 4'h0) return 0;
      if (c[3] && (c[2] || c[1])) return 1;
      return tb ? (b < n) : (b >= 2048 - n);
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_idle();
      for (k = 0; k < 9000 && busy !== 1'b0; k++) @(posedge i_ref_clk) #1;
      if (k == 9000) begin
         failures++;
         $display("[ERR] busy expected 0 seen %b", busy);
         print_verdict();
      end
   endtask
   task automatic op(input logic [1:0] kind, input logic [16:0] row,
                     input bit exp_rej);
      s_rej = 0; s_wr = 0; s_ers = 0;
      i_op_kind = kind; i_row_addr = row; i_op_req = 1;
      @(posedge i_ref_clk) #1 i_op_req = 0;
      chk("busy", 1, busy);
      wait_idle();
      chk("reject", exp_rej, s_rej);
      if (exp_rej) chk("array", 0, {s_wr, s_ers});
      if (kind == `NAP_OP_ERASE && !exp_rej)
         chk("erow", row[16:6], erow);
   endtask
   task automatic cwr(input logic [11:0] a, input logic [7:0] d);
      i_cache_wr = 1; i_cache_addr = a; i_cache_wdata = d;
      @(posedge i_ref_clk) #1 i_cache_wr = 0;
   endtask
   task automatic crd(input logic [11:0] a, input logic [7:0] d);
      i_cache_addr = a;
      @(posedge i_ref_clk) #1 chk("cache", d, rdata);
   endtask
   task automatic pulse(input bit cfg, input logic [7:0] d);
      i_cfg_data = d; i_cfg_wr = cfg; i_dev_reset = !cfg;
      @(posedge i_ref_clk) #1 {i_cfg_wr, i_dev_reset} = 2'b00;
   endtask
   initial begin
      {i_rst_n, tbs, i_cfg_wr, i_dev_reset, i_op_req, i_cache_wr} = 0;
      {bp, i_cfg_data, i_cache_wdata, i_op_kind} = 0;
      {i_row_addr, i_cache_addr, failures, num_checks, nrd} = 0;
      repeat (6) @(posedge i_ref_clk);
      #1;
      chk("reset", {2'b11, `NAP_ECC_OK}, {busy, ecc_en, stat});
      i_rst_n = 1;
      wait_idle();
      chk("boot reads", 2176, nrd);
      crd(`NAP_BAD_MARK_ADDR, `NAP_BAD_MARK_GOOD);
      $display("test reset done");
      for (t = 0; t < 2; t++) for (c = 0; c < 16; c++) begin
         tbs = t; bp = c;
         k = (c inside {[1:9]}) ? 4 << (c - 1) : 16;
         blk = '{k - 1, k, 2047 - k, 2048 - k, 0, 2047};
         foreach (blk[j]) op(prot(t, c, blk[j]) ? `NAP_OP_PROG
            : `NAP_OP_ERASE, {blk[j], 6'h2a},
            prot(t, c, blk[j]));
      end
      $display("test protect done");
      bp = 0;
      for (i = 0; i < 12'h840; i++) cwr(i, pat(i));
      op(`NAP_OP_PROG, PA, 0);
      for (i = 0; i < 12'h840; i++)
         chk("array", pat(i), u_arr.mem[{PA, i[11:0]}]);
      blk = '{11'h011, 11'h234, 11'h4ff, 11'h612, 11'h000, 11'h000};
      for (i = 0; i < 4; i++) u_arr.mem[{PA, 1'b0, blk[i]}] ^= 8'h10;
      op(`NAP_OP_READ, PA, 0);
      chk("status", `NAP_ECC_OK, stat);
      for (i = 0; i < 12'h840; i++)
         crd(i, pat(i));
      u_arr.mem[{PA, 12'h400}] ^= 8'h01;
      op(`NAP_OP_READ, PA, 0);
      chk("status", `NAP_ECC_FAIL, stat);
      $display("test correction done");
      pulse(0, 8'h00);
      chk("devrst", {1'b1, `NAP_ECC_OK}, {ecc_en, stat});
      pulse(1, 8'hef);
      chk("enable", 0, ecc_en);
      pulse(0, 8'h00);
      chk("enable", 0, ecc_en);
      op(`NAP_OP_READ, PA, 0);
      chk("status", `NAP_ECC_OK, stat);
      crd(12'h234, pat(12'h234) ^ 8'h10);
      cwr(12'h840, 8'h5a);
      op(`NAP_OP_PROG, PB, 0);
      chk("spare", 8'h5a, u_arr.mem[{PB, 12'h840}]);
      pulse(1, 8'h10);
      chk("enable", 1, ecc_en);
      $display("test bypass done");
      print_verdict();
   end
endmodule // nap_array_guard_tb_top
